// [rtl/jdc_ctrl_status.sv]
// Control, status and interrupt logic of the image decoder
// Notes on behaviour
// - Rising clock; reset returns everything to idle
// - Four-bit word address picks the register
// - Byte selects gate each written data lane
// - Write enable low reads, high writes
// - Acknowledge only after access has completed
// - Interrupt when any set status bit is unmasked
// - Master cycle spans transfers, strobe each one
// - Master always drives all four selects
// - Master drives address; memory acknowledges each
// - Status resets to 0x100; idle flag cleared by start
// - Soft reset ends decode, clears error flags
// - Start resets, clears flags, then decodes
// - Start bit always reads back zero
// - Unsupported coding sets bit six
// - Unclassified processing error sets bit five
// - Missing image marking sets bit four
// - Summary error ORs three causes, aborts
// - Output window overrun pauses; write one resumes
// - Input exhausted pauses; write one resumes
// - Done set on clean finish, cleared by reset/start
// - Writes to read-only flags are ignored
// - Mask resets zero; bit seven reads zero
// - Input byte count zero sets input empty
module jdc_ctrl_status
   import jdc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   // Host slave port
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic int_o,
   // Memory master port
   output logic m_cyc_o,
   output logic m_stb_o,
   output logic m_we_o,
   output logic [3:0] m_sel_o,
   output logic [31:0] m_adr_o,
   output logic [31:0] m_dat_o,
   input wire logic [31:0] m_dat_i,
   input wire logic m_ack_i,
   // Decoding pipeline side
   output logic dec_start,
   output logic dec_abort,
   output logic dec_run,
   input wire logic ev_unsup,
   input wire logic ev_corrupt,
   input wire logic ev_notimg,
   input wire logic ev_done,
   input wire logic ev_out_of_window,
   input wire logic in_bytes_zero,
   input wire logic pipe_req,
   input wire logic pipe_we,
   input wire logic [31:0] pipe_adr,
   input wire logic [31:0] pipe_wdat,
   input wire logic pipe_last,
   output logic pipe_ready,
   output logic [31:0] pipe_rdat,
   output logic pipe_rvalid
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Written data bit, honoured only when its byte lane is selected
   function automatic logic lane_bit(input logic [31:0] dat, input logic [3:0] sel,
                                     input int pos);
      lane_bit = dat[pos] & sel[pos / 8];
   endfunction : lane_bit

   // Merge selected byte lanes of new data over old data
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            res[i*8 +: 8] = dat[i*8 +: 8];
      end
      lane_merge = res;
   endfunction : lane_merge

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   jdc_state_t state_reg; // Decoder control state
   jdc_state_t state_next; // Next control state
   logic ack_reg; // Slave acknowledge
   logic acc; // New slave access this cycle
   logic wr_stat; // Write to status
   logic wr_mask; // Write to mask
   logic wr_srst; // Soft reset requested
   logic wr_start; // Start requested
   logic clr_all; // Clear of all cause flags
   logic clr_wfull; // Write one to output full
   logic clr_rempty; // Write one to input empty
   logic run_st; // Decode active (maybe paused)
   logic set_unsup; // Unsupported event taken
   logic set_corrupt; // Corruption event taken
   logic set_notimg; // Not-an-image event taken
   logic set_err; // Any error event taken
   logic set_done; // Clean finish taken
   logic set_wfull; // Window overrun taken
   logic set_rempty; // Input exhaustion taken
   logic unsup_reg; // Unsupported flag
   logic corrupt_reg; // Corrupt flag
   logic notimg_reg; // Not-an-image flag
   logic wfull_reg; // Output full flag
   logic rempty_reg; // Input empty flag
   logic done_reg; // Done flag
   logic err_flag; // Summary error
   logic [8:0] mask_reg; // Interrupt enables
   logic [31:0] status_view; // Status as read

   jdc_mst_if mst_ch (); // Channel to master

   // ----------------------------------------------------------------
   // Slave access decode
   // ----------------------------------------------------------------
   assign acc = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_stat = acc & wb_we_i & (wb_adr_i == JDC_ADR_STATUS);
   assign wr_mask = acc & wb_we_i & (wb_adr_i == JDC_ADR_MASK);
   assign wr_srst = wr_stat & lane_bit(wb_dat_i, wb_sel_i, JDC_BIT_SRST);
   assign wr_start = wr_stat & lane_bit(wb_dat_i, wb_sel_i, JDC_BIT_START);
   assign clr_all = wr_srst | wr_start;
   assign clr_wfull = wr_stat & lane_bit(wb_dat_i, wb_sel_i, JDC_BIT_WFULL);
   assign clr_rempty = wr_stat & lane_bit(wb_dat_i, wb_sel_i, JDC_BIT_REMPTY);

   // Acknowledge one cycle after the access is carried out
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= acc;
   end

   // Read data captured with the access
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         wb_dat_o <= '0;
      else if (acc && !wb_we_i)
      begin
         case (wb_adr_i)
            JDC_ADR_STATUS: wb_dat_o <= status_view;
            JDC_ADR_MASK: wb_dat_o <= {23'h000000, mask_reg};
            default: wb_dat_o <= '0; // Unmapped reads zero
         endcase
      end
   end

   assign wb_ack_o = ack_reg;

   // ----------------------------------------------------------------
   // Event qualification
   // ----------------------------------------------------------------
   assign run_st = (state_reg == ST_RUN);
   assign set_unsup = run_st & ev_unsup;
   assign set_corrupt = run_st & ev_corrupt;
   assign set_notimg = run_st & ev_notimg;
   assign set_err = set_unsup | set_corrupt | set_notimg;
   assign set_done = run_st & ev_done & ~set_err;
   assign set_wfull = run_st & ev_out_of_window;
   assign set_rempty = run_st & in_bytes_zero & ~ev_done;

   // ----------------------------------------------------------------
   // Status flags; an event in the clearing cycle wins
   // ----------------------------------------------------------------
   // Error cause flags, read only to the host
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         unsup_reg <= JDC_STATUS_RST[JDC_BIT_UNSUP];
         corrupt_reg <= JDC_STATUS_RST[JDC_BIT_CORRUPT];
         notimg_reg <= JDC_STATUS_RST[JDC_BIT_NOTIMG];
      end
      else
      begin
         unsup_reg <= (unsup_reg & ~clr_all) | set_unsup;
         corrupt_reg <= (corrupt_reg & ~clr_all) | set_corrupt;
         notimg_reg <= (notimg_reg & ~clr_all) | set_notimg;
      end
   end

   // Pause flags, cleared by writing one
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wfull_reg <= JDC_STATUS_RST[JDC_BIT_WFULL];
         rempty_reg <= JDC_STATUS_RST[JDC_BIT_REMPTY];
      end
      else
      begin
         wfull_reg <= (wfull_reg & ~(clr_all | clr_wfull)) | set_wfull;
         rempty_reg <= (rempty_reg & ~(clr_all | clr_rempty)) | set_rempty;
      end
   end

   // Done flag, cleared only by soft reset or start
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         done_reg <= JDC_STATUS_RST[JDC_BIT_DONE];
      else
         done_reg <= (done_reg & ~clr_all) | set_done;
   end

   // Summary error follows its three causes
   assign err_flag = unsup_reg | corrupt_reg | notimg_reg;

   // ----------------------------------------------------------------
   // Decoder control state
   // ----------------------------------------------------------------
   // Soft reset beats an error event, and an error event beats start
   always_comb
   begin
      state_next = state_reg;
      if (wr_srst)
         state_next = ST_IDLE;
      else if (set_err)
         state_next = ST_ERR;
      else if (wr_start)
         state_next = ST_RUN;
      else
      begin
         case (state_reg)
            ST_RUN:
               if (set_err)
                  state_next = ST_ERR;
               else if (set_done)
                  state_next = ST_DONE;
            ST_IDLE: state_next = ST_IDLE;
            ST_DONE: state_next = ST_DONE;
            ST_ERR: state_next = ST_ERR;
            default: state_next = ST_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Pulses to the pipeline
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dec_start <= 1'b0;
         dec_abort <= 1'b0;
      end
      else
      begin
         dec_start <= wr_start & ~wr_srst & ~set_err;
         dec_abort <= clr_all;
      end
   end

   // Pipeline may move only while running and not paused
   assign dec_run = run_st & ~wfull_reg & ~rempty_reg;

   // ----------------------------------------------------------------
   // Interrupt mask and output
   // ----------------------------------------------------------------
   // Mask register; bit 7 never stored
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         mask_reg <= JDC_MASK_RST;
      else if (wr_mask)
         mask_reg <= JDC_FLAG_W'(lane_merge({23'h000000, mask_reg}, wb_dat_i, wb_sel_i))
                     & JDC_MASK_WRBITS;
   end

   // Readable status word; start reads zero
   assign status_view = {23'h000000, (state_reg == ST_IDLE), 1'b0, unsup_reg, corrupt_reg,
                         notimg_reg, err_flag, wfull_reg, rempty_reg, done_reg};

   // Level interrupt of any enabled status bit
   assign int_o = |(status_view[JDC_FLAG_W-1:0] & mask_reg);

   // ----------------------------------------------------------------
   // Memory master
   // ----------------------------------------------------------------
   assign mst_ch.req = pipe_req & dec_run; // Pause holds new transfers
   assign mst_ch.we = pipe_we;
   assign mst_ch.adr = pipe_adr;
   assign mst_ch.wdat = pipe_wdat;
   assign mst_ch.last = pipe_last;
   assign mst_ch.abort = dec_abort | ~run_st; // Close a cut chain once not running
   assign pipe_ready = mst_ch.ready & dec_run;
   assign pipe_rdat = mst_ch.rdat;
   assign pipe_rvalid = mst_ch.rvalid;

   // Bus master instance
   jdc_wb_master u_master (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .mp(mst_ch.mst),
      .m_cyc_o(m_cyc_o),
      .m_stb_o(m_stb_o),
      .m_we_o(m_we_o),
      .m_sel_o(m_sel_o),
      .m_adr_o(m_adr_o),
      .m_dat_o(m_dat_o),
      .m_dat_i(m_dat_i),
      .m_ack_i(m_ack_i)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   ack_follows_req_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> (wb_ack_o ##1 !wb_ack_o))
      else $error("slave ack not one cycle after request");
   irq_unmasked_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (mask_reg[2] && wfull_reg) || (mask_reg[8] && state_reg == ST_IDLE) |-> int_o)
      else $error("interrupt missing for enabled flag");
   start_reads_zero_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         wb_ack_o |-> !wb_dat_o[7])
      else $error("start bit read back as one");
   err_summary_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         err_flag |-> (!dec_run && state_reg != ST_RUN) || $past(wr_start))
      else $error("error did not abort decode");
   srst_clears_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (wr_srst && !set_err && !set_done && !set_wfull && !set_rempty) |=>
         (state_reg == ST_IDLE && !err_flag && !wfull_reg && !rempty_reg && !done_reg))
      else $error("soft reset left flags set");
   start_runs_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (wr_start && !wr_srst && !set_err) |=> (state_reg == ST_RUN && dec_start ##1 !dec_start))
      else $error("start did not begin decode");
   mask_bit7_zero_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n) !mask_reg[7])
      else $error("mask bit 7 stored");
   done_holds_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (done_reg && !clr_all) |=> done_reg)
      else $error("done flag lost without clear");
   pause_stops_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (set_wfull && !clr_all) |=> (wfull_reg && !dec_run))
      else $error("window overrun did not pause");

endmodule : jdc_ctrl_status

// [rtl/jdc_pkg.sv]
// Constants shared by the decoder control and status block
package jdc_pkg;

   // ----------------------------------------------------------------
   // Register word addresses on the host slave port
   // ----------------------------------------------------------------
   localparam logic [3:0] JDC_ADR_STATUS = 4'h0; // Decoder status
   localparam logic [3:0] JDC_ADR_MASK = 4'h1; // Interrupt enable mask

   // ----------------------------------------------------------------
   // Bit positions inside the status and mask registers
   // ----------------------------------------------------------------
   localparam int JDC_BIT_DONE = 0; // Image finished
   localparam int JDC_BIT_REMPTY = 1; // Input exhausted
   localparam int JDC_BIT_WFULL = 2; // Output window full
   localparam int JDC_BIT_ERR = 3; // Summary error
   localparam int JDC_BIT_NOTIMG = 4; // Not an image
   localparam int JDC_BIT_CORRUPT = 5; // Corrupt stream
   localparam int JDC_BIT_UNSUP = 6; // Unsupported coding
   localparam int JDC_BIT_START = 7; // Start, write only
   localparam int JDC_BIT_SRST = 8; // Soft reset / idle

   // ----------------------------------------------------------------
   // Reset values and writable bit masks
   // ----------------------------------------------------------------
   localparam logic [31:0] JDC_STATUS_RST = 32'h0000_0100; // Status after reset
   localparam logic [8:0] JDC_MASK_RST = 9'h000; // Mask after reset
   localparam logic [8:0] JDC_MASK_WRBITS = 9'h17f; // Bit 7 not stored
   localparam int JDC_FLAG_W = 9; // Implemented low bits

   // ----------------------------------------------------------------
   // Master port constants
   // ----------------------------------------------------------------
   localparam logic [3:0] JDC_SEL_ALL = 4'hf; // Full word lanes

   // Decoder control states
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE, ST_ERR} jdc_state_t;

endpackage : jdc_pkg

// [rtl/jdc_mst_if.sv]
// Request channel between the control block and its memory master
interface jdc_mst_if;
   logic req; // Transfer request
   logic we; // 1 write, 0 read
   logic [31:0] adr; // Byte address
   logic [31:0] wdat; // Write data
   logic last; // Final transfer of a bus cycle
   logic abort; // Close an open cycle between transfers
   logic ready; // Request taken this cycle
   logic [31:0] rdat; // Read data
   logic rvalid; // Transfer completed pulse

   // Control side issues requests
   modport ctrl (output req, we, adr, wdat, last, abort, input ready, rdat, rvalid);
   // Master side serves them
   modport mst (input req, we, adr, wdat, last, abort, output ready, rdat, rvalid);
endinterface : jdc_mst_if

// [rtl/jdc_wb_master.sv]
// Memory bus master that runs single or chained full-word transfers
module jdc_wb_master
   import jdc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   jdc_mst_if.mst mp,
   output logic m_cyc_o,
   output logic m_stb_o,
   output logic m_we_o,
   output logic [3:0] m_sel_o,
   output logic [31:0] m_adr_o,
   output logic [31:0] m_dat_o,
   input wire logic [31:0] m_dat_i,
   input wire logic m_ack_i
);

   // ----------------------------------------------------------------
   // Transfer state
   // ----------------------------------------------------------------
   logic cyc_reg; // Bus cycle open
   logic stb_reg; // Transfer outstanding
   logic last_reg; // Current transfer closes cycle
   logic take; // Request accepted
   logic done; // Outstanding transfer acknowledged

   assign take = mp.req & ~stb_reg;
   assign done = stb_reg & m_ack_i;
   assign mp.ready = ~stb_reg;

   // Strobe marks each single transfer
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         stb_reg <= 1'b0;
      else if (take)
         stb_reg <= 1'b1;
      else if (done)
         stb_reg <= 1'b0;
   end

   // Cycle stays up across a chain of transfers
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         cyc_reg <= 1'b0;
      else if (take)
         cyc_reg <= 1'b1;
      else if (done && last_reg)
         cyc_reg <= 1'b0;
      else if (mp.abort && !stb_reg)
         cyc_reg <= 1'b0; // Abandoned chain
   end

   // Address, direction and data latched on acceptance
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         m_adr_o <= '0;
         m_dat_o <= '0;
         m_we_o <= 1'b0;
         last_reg <= 1'b0;
      end
      else if (take)
      begin
         m_adr_o <= mp.adr;
         m_dat_o <= mp.wdat;
         m_we_o <= mp.we;
         last_reg <= mp.last;
      end
   end

   // Read data and completion back to the requester
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mp.rdat <= '0;
         mp.rvalid <= 1'b0;
      end
      else
      begin
         mp.rvalid <= done;
         if (done && !m_we_o)
            mp.rdat <= m_dat_i;
      end
   end

   assign m_cyc_o = cyc_reg;
   assign m_stb_o = stb_reg;
   assign m_sel_o = JDC_SEL_ALL;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   stb_in_cyc_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n) m_stb_o |-> m_cyc_o)
      else $error("strobe outside cycle");
   sel_full_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         m_cyc_o |-> m_sel_o == 4'hf)
      else $error("master select not full word");
   adr_held_a:
      assert property (@(posedge clk_sys) disable iff (!reset_n)
         (m_stb_o && !m_ack_i) |=> (m_stb_o && $stable(m_adr_o) && $stable(m_we_o)))
      else $error("master transfer changed before ack");

endmodule : jdc_wb_master

// [verif/jdc_mem_model.sv]
// Memory on the far side of the decoder's master port
module jdc_mem_model
   import jdc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic slow,
   input wire logic m_cyc_o,
   input wire logic m_stb_o,
   input wire logic m_we_o,
   input wire logic [31:0] m_adr_o,
   input wire logic [31:0] m_dat_o,
   output logic [31:0] m_dat_i,
   output logic m_ack_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:15]; // Small word store
   logic [1:0] wait_cnt; // Wait states in slow mode
   // Answer each strobed transfer once it is done
   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         m_ack_i <= 1'b0;
         wait_cnt <= 2'h0;
         m_dat_i <= 32'h5a5a_a5a5;
      end
      else if (m_cyc_o && m_stb_o && !m_ack_i)
      begin
         if (slow && wait_cnt != 2'h2)
            wait_cnt <= wait_cnt + 2'h1;
         else
         begin
            m_ack_i <= 1'b1;
            wait_cnt <= 2'h0;
            if (m_we_o)
               mem[m_adr_o[5:2]] <= m_dat_o;
            else
               m_dat_i <= mem[m_adr_o[5:2]];
         end
      end
      else
      begin
         // Released data never holds its last value
         m_ack_i <= 1'b0;
         m_dat_i <= ~m_dat_i;
      end
   end
endmodule : jdc_mem_model

// [verif/jdc_ctrl_status_tb.sv]
// Self-checking bench of the decoder control and status block
module jdc_ctrl_status_tb;
   import jdc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, reset_n, cyc, stb, we, slow;
   logic [3:0] adr, sel;
   logic [31:0] wdat, rdat, m_dat_i, m_adr_o, m_dat_o, pipe_adr, pipe_wdat, pipe_rdat;
   logic ack, int_o, m_cyc_o, m_stb_o, m_we_o, m_ack_i, dec_run, dec_start, dec_abort;
   logic [1:0] dpl; // Start and abort pulses seen at the last ack
   logic pipe_req, pipe_we, pipe_last, pipe_ready, pipe_rvalid;
   logic [3:0] m_sel_o;
   logic [5:0] ev; // unsup, corrupt, notimg, done, window, bytes zero
   int fail_count = 0, checks = 0, cycles = 0;
   jdc_ctrl_status dut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .int_o(int_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o), .m_we_o(m_we_o),
      .m_sel_o(m_sel_o), .m_adr_o(m_adr_o), .m_dat_o(m_dat_o), .m_dat_i(m_dat_i),
      .m_ack_i(m_ack_i), .dec_start(dec_start), .dec_abort(dec_abort), .dec_run(dec_run),
      .ev_unsup(ev[0]),
      .ev_corrupt(ev[1]), .ev_notimg(ev[2]), .ev_done(ev[3]), .ev_out_of_window(ev[4]),
      .in_bytes_zero(ev[5]), .pipe_req(pipe_req), .pipe_we(pipe_we), .pipe_adr(pipe_adr),
      .pipe_wdat(pipe_wdat), .pipe_last(pipe_last), .pipe_ready(pipe_ready),
      .pipe_rdat(pipe_rdat), .pipe_rvalid(pipe_rvalid));
   jdc_mem_model mem (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow), .m_cyc_o(m_cyc_o),
      .m_stb_o(m_stb_o), .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_dat_o(m_dat_o),
      .m_dat_i(m_dat_i), .m_ack_i(m_ack_i));
   // Clock of 40 ns period
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Closing report
   task test_done;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   // Compare seen against expected
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // One slave access; entered just after an edge
   task bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d,
      input logic [31:0] e);
      int n;
      n = 0;
      cyc = 1'b1; stb = 1'b1; we = w; adr = a; sel = s; wdat = d;
      do begin @(posedge clk_sys); n++; end while (!ack && n < 20);
      dpl = {dec_start, dec_abort};
      if (!w) chk("read data", rdat, e);
      chk("ack latency", n, 2);
      #1 cyc = 1'b0; stb = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : bus
   // One pipeline request through the master port
   task mtx(input logic w, input logic [31:0] a, input logic [31:0] d, input logic l,
      input logic [31:0] e);
      int n;
      n = 0;
      pipe_we = w; pipe_adr = a; pipe_wdat = d; pipe_last = l; pipe_req = 1'b1;
      do begin @(posedge clk_sys); n++; end while (!pipe_ready && n < 20);
      #1 pipe_req = 1'b0;
      chk("m_stb_o", {31'h0, m_stb_o}, 32'h1);
      chk("m_sel_o", {28'h0, m_sel_o}, 32'hf);
      chk("m_adr_o", m_adr_o, a);
      chk("m_we_o", {31'h0, m_we_o}, {31'h0, w});
      do begin @(posedge clk_sys); n++; end while (!pipe_rvalid && n < 40);
      chk("pipe_rvalid", {31'h0, pipe_rvalid}, 32'h1);
      if (!w) chk("pipe_rdat", pipe_rdat, e);
      #1;
   endtask : mtx
   // One-cycle event from the pipeline
   task pulse(input int i);
      ev[i] = 1'b1;
      @(posedge clk_sys);
      #1 ev = 6'h0;
   endtask : pulse
   // Hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         test_done;
      end
   end
   // Main sequence
   initial
   begin
      reset_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
      wdat = 32'h0; slow = 1'b0; ev = 6'h0; pipe_req = 1'b0; pipe_we = 1'b0;
      pipe_adr = 32'h0; pipe_wdat = 32'h0; pipe_last = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      bus(0, 4'h0, 4'hf, 32'h0, 32'h0000_0100);
      bus(0, 4'h1, 4'hf, 32'h0, 32'h0);
      bus(0, 4'h5, 4'hf, 32'h0, 32'h0);
      bus(1, 4'h1, 4'hf, 32'hffff_ffff, 32'h0);
      bus(0, 4'h1, 4'hf, 32'h0, 32'h0000_017f);
      chk("int_o", {31'h0, int_o}, 32'h1);
      bus(1, 4'h1, 4'h1, 32'h0000_0001, 32'h0);
      bus(0, 4'h1, 4'hf, 32'h0, 32'h0000_0101);
      chk("int_o", {31'h0, int_o}, 32'h1);
      bus(1, 4'h0, 4'h1, 32'h0000_0080, 32'h0);
      chk("dec pulses", {30'h0, dpl}, 32'h3);
      chk("int_o", {31'h0, int_o}, 32'h0);
      bus(0, 4'h0, 4'hf, 32'h0, 32'h0);
      mtx(1, 32'h40, 32'hcafe_f00d, 0, 32'h0);
      chk("m_cyc_o", {31'h0, m_cyc_o}, 32'h1);
      slow = 1'b1;
      mtx(0, 32'h40, 32'h0, 1, 32'hcafe_f00d);
      chk("m_cyc_o", {31'h0, m_cyc_o}, 32'h0);
      pulse(4);
      bus(0, 4'h0, 4'hf, 32'h0, 32'h4);
      chk("pipe_ready", {31'h0, pipe_ready}, 32'h0);
      pulse(5);
      bus(0, 4'h0, 4'hf, 32'h0, 32'h6);
      bus(1, 4'h0, 4'h1, 32'h6, 32'h0);
      bus(0, 4'h0, 4'hf, 32'h0, 32'h0);
      pulse(3);
      bus(0, 4'h0, 4'hf, 32'h0, 32'h1);
      chk("int_o", {31'h0, int_o}, 32'h1);
      for (int i = 0; i < 3; i++)
      begin
         bus(1, 4'h0, 4'h1, 32'h80, 32'h0);
         chk("dec pulses", {30'h0, dpl}, 32'h3);
         pulse(i);
         bus(0, 4'h0, 4'hf, 32'h0, (32'h40 >> i) | 32'h8);
         chk("dec_run", {31'h0, dec_run}, 32'h0);
         bus(1, 4'h0, 4'hf, 32'h0000_007f, 32'h0);
         bus(1, 4'h0, 4'h1, 32'h0000_0100, 32'h0);
         bus(0, 4'h0, 4'hf, 32'h0, (32'h40 >> i) | 32'h8);
         bus(1, 4'h0, 4'h2, 32'h0000_0100, 32'h0);
         chk("dec pulses", {30'h0, dpl}, 32'h1);
         bus(0, 4'h0, 4'hf, 32'h0, 32'h0000_0100);
      end
      test_done;
   end
endmodule : jdc_ctrl_status_tb
